// ### src/adc_serial_pkg.sv
// Purpose: shared constants and types for the serial state block
// Assumes: core clock of 125 MHz (8 ns period)
// Notes:   timing counts derive from times in ns
package adc_serial_pkg;

  localparam int          ClkPeriodNs  = 8;
  localparam int          WordBits     = 32;
  localparam int          CountBits    = 7;
  localparam int          FifoDepth    = 4;
  localparam logic [31:0] NopWord      = 32'h0000_0000;
  // conversion and reset recovery times, as nanoseconds
  localparam int          ConvTimeNs   = 660;
  localparam int          PorDelayNs   = 20000;
  localparam int          AppDelayNs   = 1000;
  localparam int          ConvCycles   = (ConvTimeNs + ClkPeriodNs - 1)
                                         / ClkPeriodNs;
  localparam int          PorCycles    = (PorDelayNs + ClkPeriodNs - 1)
                                         / ClkPeriodNs;
  localparam int          AppCycles    = (AppDelayNs + ClkPeriodNs - 1)
                                         / ClkPeriodNs;
  localparam int          TimerBits    = 16;
  localparam logic [6:0]  FullFrame    = 7'h20;

  typedef enum logic [1:0]
  {
    ST_RESET = 2'b00,
    ST_ACQ   = 2'b01,
    ST_CONV  = 2'b10
  } dev_state_e;

  // one decoded frame handed to the command side
  typedef struct packed
  {
    logic [31:0] word;
    logic        longEnough;
  } frame_word_s;

endpackage : adc_serial_pkg

// ### src/frame_fifo.sv
// Purpose: small word fifo between frame capture and command side
// Assumes: single clock, synchronous active-low reset
// Notes:   depth must be a power of two
`timescale 1ns/10ps
`default_nettype none
module frame_fifo
#(
  parameter int Width = 33,
  parameter int Depth = 4
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // filling side
  input  wire logic [Width-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  // draining side
  output logic      [Width-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int AW = $clog2(Depth);

  logic [Width-1:0] mem [Depth];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  logic             doWrite;
  logic             doRead;

  // honest full and empty from pointer compare
  assign inReady  = (wrPtr[AW] == rdPtr[AW])
                    || (wrPtr[AW-1:0] != rdPtr[AW-1:0]);
  assign outValid = (wrPtr != rdPtr);
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;
  assign outData  = mem[rdPtr[AW-1:0]];

  // storage
  always_ff @(posedge core_clk)
  begin
    if (doWrite)
      mem[wrPtr[AW-1:0]] <= inData;
  end

  // pointers
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      if (doWrite)
        wrPtr <= wrPtr + 1'b1;
      if (doRead)
        rdPtr <= rdPtr + 1'b1;
    end
  end

  fifo_data_hold_a : assert property (@(posedge core_clk)
    disable iff (!nrst)
    (outValid && !outReady) |=> $stable(outData))
    else $error("head word changed while stalled");

endmodule : frame_fifo
`default_nettype wire

// ### src/pin_sync.sv
// Purpose: three-stage pin synchroniser with agreement output
// Assumes: input from outside the core clock domain
// Notes:   stage one feeds stage two only
`timescale 1ns/10ps
`default_nettype none
module pin_sync
#(
  parameter int Width = 4
)
(
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // pins and filtered level
  input  wire logic [Width-1:0] pinIn,
  input  wire logic [Width-1:0] resetVal,
  output logic      [Width-1:0] level
);

  logic [Width-1:0] s1;
  logic [Width-1:0] s2;
  logic [Width-1:0] s3;

  // a change counts once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < Width; i++)
    begin : g_bit
      always_ff @(posedge core_clk)
      begin
        if (!nrst)
        begin
          // all stages start at the idle level, so no false edge
          s1[i]    <= resetVal[i];
          s2[i]    <= resetVal[i];
          s3[i]    <= resetVal[i];
          level[i] <= resetVal[i];
        end
        else
        begin
          s1[i] <= pinIn[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i])
            level[i] <= s3[i];
        end
      end
    end
  endgenerate

endmodule : pin_sync
`default_nettype wire

// ### src/adc_serial_state.sv
// Purpose: serial shift frame and state control of the converter
// Assumes: link clock sampled by core_clk; mode 0 (capture on rise)
// Notes:   no software registers; reset select is a plain input
`timescale 1ns/10ps
`default_nettype none
module adc_serial_state
  import adc_serial_pkg::*;
#(
  parameter int ConvCount = ConvCycles,
  parameter int PorCount  = PorCycles,
  parameter int AppCount  = AppCycles
)
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // host pins
  input  wire logic        conv_start_select_n,
  input  wire logic        sclk,
  input  wire logic        serialIn,
  input  wire logic        async_reset_n,
  output logic             primary_serial_out,
  output logic             primarySerialOutEn_n,
  output logic             ready_strobe,
  // configuration
  input  wire logic        app_reset_select,
  // converter side
  input  wire logic [31:0] outputWord,
  output logic             sampleStart,
  output logic             appResetPulse,
  output logic             porResetPulse,
  // decoded command words
  output logic [31:0]      cmdWord,
  output logic             cmdFull,
  output logic             cmdValid,
  input  wire logic        cmdReady
);

  dev_state_e       state;
  dev_state_e       next_state;
  logic [3:0]       pins;
  logic [3:0]       pinsQ;
  logic             csLvl;
  logic             sclkLvl;
  logic             sdiLvl;
  logic             rstLvl;
  logic             csPrev;
  logic             sclkPrev;
  logic             rstPrev;
  logic             csFall;
  logic             csRise;
  logic             sclkRise;
  logic             sclkFall;
  logic             rstFall;
  logic             rstRise;
  logic             inFrame;
  logic [31:0]      inShift;
  logic [31:0]      outShift;
  logic [CountBits-1:0] sclkCount;
  logic [TimerBits-1:0] timer;
  logic             recovering;
  logic             appMode;
  frame_word_s      fifoIn;
  frame_word_s      fifoOut;
  logic             fifoInReady;

  // every pin passes four flops before use
  pin_sync #(.Width(4)) u_sync
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pinIn    ({async_reset_n, serialIn, sclk, conv_start_select_n}),
    .resetVal (4'hD),  // link clock idles low, the rest high
    .level    (pinsQ)
  );

  assign pins    = pinsQ;
  assign csLvl   = pins[0];
  assign sclkLvl = pins[1];
  assign sdiLvl  = pins[2];
  assign rstLvl  = pins[3];

  // edge memory of the filtered levels
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      csPrev   <= 1'b1;
      sclkPrev <= 1'b0;
      rstPrev  <= 1'b1;
    end
    else
    begin
      csPrev   <= csLvl;
      sclkPrev <= sclkLvl;
      rstPrev  <= rstLvl;
    end
  end

  assign csFall   = csPrev && !csLvl;
  assign csRise   = !csPrev && csLvl;
  assign sclkRise = !sclkPrev && sclkLvl;
  assign sclkFall = sclkPrev && !sclkLvl;
  assign rstFall  = rstPrev && !rstLvl;
  assign rstRise  = !rstPrev && rstLvl;

  // state transitions; select, reset and the timer steer them
  always_comb
  begin
    next_state = state;
    case (state)
      ST_RESET:
        if (rstLvl && timer == '0 && recovering)
          next_state = ST_ACQ;
      ST_ACQ:
        if (rstFall)
          next_state = ST_RESET;
        else if (csRise)
          next_state = ST_CONV;
      ST_CONV:
        if (rstFall)
          next_state = ST_RESET;
        else if (timer == '0)
          next_state = ST_ACQ;
      default:
        next_state = ST_RESET;
    endcase
  end

  // state register; entering the reset state after reset
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      state <= ST_RESET;
    else
      state <= next_state;
  end

  // remember which reset was asked for at reset fall
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      appMode <= 1'b0;
    else if (rstFall)
      appMode <= app_reset_select;
  end

  // one shared timer for conversion and recovery; the select pin
  // is not looked at while it runs, so extra edges are ignored
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      timer      <= TimerBits'(PorCount);
      recovering <= 1'b1;
    end
    else if (!rstLvl)
    begin
      timer      <= '0;
      recovering <= 1'b0;
    end
    else if (state == ST_RESET && !recovering)
    begin
      timer      <= appMode ? TimerBits'(AppCount)
                            : TimerBits'(PorCount);
      recovering <= 1'b1;
    end
    else if (state == ST_ACQ && csRise)
      timer <= TimerBits'(ConvCount);
    else if (timer != '0)
      timer <= timer - 1'b1;
  end

  // reset pulses to the converter side
  assign appResetPulse = rstFall && app_reset_select;
  assign porResetPulse = rstFall && !app_reset_select;
  assign sampleStart   = (state == ST_ACQ) && csRise;

  // frame window: open on select fall while acquiring
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      inFrame <= 1'b0;
    else if (state != ST_ACQ || csRise)
      inFrame <= 1'b0;
    else if (csFall)
      inFrame <= 1'b1;
  end

  // input shift register and capture counter
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      inShift   <= NopWord;
      sclkCount <= '0;
    end
    else if (state == ST_ACQ && csFall)
    begin
      inShift   <= NopWord;
      sclkCount <= '0;
    end
    else if (inFrame && sclkRise)
    begin
      inShift <= {inShift[WordBits-2:0], sdiLvl};
      if (sclkCount != FullFrame)
        sclkCount <= sclkCount + 1'b1;
    end
  end

  // output shift register: load on select fall, shift on launch
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      outShift <= '0;
    else if (state == ST_ACQ && csFall)
      outShift <= outputWord;
    // captured bits follow the output word, so a chain passes data on
    else if (inFrame && sclkFall)
      outShift <= {outShift[WordBits-2:0], inShift[0]};
  end

  // serial output and its enable, active low
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      primary_serial_out   <= 1'b0;
      primarySerialOutEn_n <= 1'b1;
    end
    else if (!rstLvl || csRise || state != ST_ACQ)
    begin
      primary_serial_out   <= 1'b0;
      primarySerialOutEn_n <= 1'b1;
    end
    else if (csFall)
    begin
      primary_serial_out   <= outputWord[WordBits-1];
      primarySerialOutEn_n <= 1'b0;
    end
    else if (inFrame && sclkFall)
      primary_serial_out <= outShift[WordBits-2];
  end

  // ready strobe: high only while acquiring outside a frame
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      ready_strobe <= 1'b0;
    else
      ready_strobe <= (next_state == ST_ACQ) && !(state == ST_ACQ
                      && (csFall || csRise)) && !inFrame
                      && !(state == ST_ACQ && !csLvl);
  end

  // completed frame handed to the command side; short frames
  // become no-operation words
  assign fifoIn.word       = (sclkCount >= FullFrame) ? inShift
                                                      : NopWord;
  assign fifoIn.longEnough = (sclkCount >= FullFrame);

  frame_fifo #(.Width(33), .Depth(FifoDepth)) u_fifo
  (
    .core_clk (core_clk),
    .nrst     (nrst),
    .inData   (fifoIn),
    .inValid  (state == ST_ACQ && csRise && inFrame),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (cmdValid),
    .outReady (cmdReady)
  );

  assign cmdWord = fifoOut.word;
  assign cmdFull = fifoOut.longEnough;

  conv_ignores_cs_a : assert property (@(posedge core_clk)
    disable iff (!nrst)
    (state == ST_CONV && rstLvl && timer != '0) |=> state == ST_CONV)
    else $error("conversion left early");
  conv_start_a : assert property (@(posedge core_clk)
    disable iff (!nrst)
    (state == ST_ACQ && csRise && rstLvl) |=> state == ST_CONV)
    else $error("select rise did not convert");
  conv_ends_a : assert property (@(posedge core_clk)
    disable iff (!nrst)
    (state == ST_CONV && timer == '0 && rstLvl) |=> state == ST_ACQ)
    else $error("conversion did not end in acquire");
  reset_enter_a : assert property (@(posedge core_clk)
    disable iff (!nrst)
    (state != ST_RESET && rstFall) |=> state == ST_RESET)
    else $error("reset fall ignored");
  strobe_low_reset_a : assert property (@(posedge core_clk)
    disable iff (!nrst)
    (state == ST_RESET) |=> !ready_strobe || state == ST_ACQ)
    else $error("strobe high in reset");
  tristate_rise_a : assert property (@(posedge core_clk)
    disable iff (!nrst)
    csRise |=> primarySerialOutEn_n && !ready_strobe)
    else $error("output driven after select rise");
  drive_fall_a : assert property (@(posedge core_clk)
    disable iff (!nrst)
    (state == ST_ACQ && csFall && rstLvl) |=> !primarySerialOutEn_n
      && primary_serial_out == $past(outputWord[31]))
    else $error("select fall did not drive msb");
  shift_capture_a : assert property (@(posedge core_clk)
    disable iff (!nrst)
    (inFrame && sclkRise && !csRise && state == ST_ACQ && rstLvl)
      |=> inShift[0] == $past(sdiLvl))
    else $error("capture bit lost");
  recover_acq_a : assert property (@(posedge core_clk)
    disable iff (!nrst)
    (state == ST_RESET && $past(state) == ST_RESET && rstLvl
      && recovering && timer == '0) |=> state == ST_ACQ)
    else $error("recovery did not reach acquire");

endmodule : adc_serial_state
`default_nettype wire

// ### sim/spi_host_model.sv
// Purpose: host controller model for the serial frame pins
// Assumes: capture on link clock rise, link clock idle low, 160 ns period
// Notes:   released data line shows the inverse of its last bit
`timescale 1ns/10ps
`default_nettype none
module spi_host_model
(
  // pins toward the device
  output logic      conv_start_select_n,
  output logic      sclk,
  output logic      serialIn,
  input  wire logic primary_serial_out
);
  localparam int HalfNs = 80;

  // idle pins: select high, link clock still and low
  initial
  begin
    conv_start_select_n = 1'b1;
    sclk                = 1'b0;
    serialIn            = 1'b0;
  end

  // one frame of nBits captures, only select, clock and data used
  task automatic frame(input logic [63:0] tx, input int nBits,
                       output logic [63:0] rx);
    int i;
    rx = '0;
    #3 conv_start_select_n = 1'b0;
    serialIn = tx[nBits-1];
    #(HalfNs);
    // last 32 bits sent become the word, msb first
    for (i = nBits - 1; i >= 0; i--)
    begin
      sclk = 1'b1;
      rx = {rx[62:0], primary_serial_out};
      #(HalfNs);
      sclk = 1'b0;
      if (i > 0)
        serialIn = tx[i-1];
      #(HalfNs);
    end
    conv_start_select_n = 1'b1;
    serialIn = ~serialIn;
  endtask : frame

  // select pulse without clocks, used while a conversion runs
  task automatic pulse_select(input int lowNs);
    #3 conv_start_select_n = 1'b0;
    #(lowNs) conv_start_select_n = 1'b1;
  endtask : pulse_select

  // select level held directly, used around a reset release
  task automatic hold_select(input logic lvl);
    conv_start_select_n = lvl;
  endtask : hold_select
endmodule : spi_host_model
`default_nettype wire

// ### sim/adc_serial_state_tb.sv
// Purpose: self-checking bench for the serial state block
// Assumes: shortened conversion and recovery counts
// Notes:   decoded words are checked from a queue of expectations
`timescale 1ns/10ps
`default_nettype none
module adc_serial_state_tb;
  import adc_serial_pkg::*;
  localparam int ConvN = 40;
  localparam int PorN  = 20;
  localparam int AppN  = 10;

  logic        core_clk, nrst, async_reset_n, app_reset_select, cmdReady;
  logic        conv_start_select_n, sclk, serialIn, primary_serial_out;
  logic        primarySerialOutEn_n, ready_strobe, sampleStart;
  logic        appResetPulse, porResetPulse, cmdFull, cmdValid;
  logic [31:0] outputWord, cmdWord;
  logic [63:0] rx, tx;
  logic        lastSdo, sdoLine;
  int          failures, comparisons, appSeen, porSeen, startSeen, n, s0;
  frame_word_s expQ[$];
  frame_word_s got;

  adc_serial_state #(.ConvCount(ConvN), .PorCount(PorN), .AppCount(AppN))
  DUT (.core_clk(core_clk), .nrst(nrst),
       .conv_start_select_n(conv_start_select_n), .sclk(sclk),
       .serialIn(serialIn), .async_reset_n(async_reset_n),
       .primary_serial_out(primary_serial_out),
       .primarySerialOutEn_n(primarySerialOutEn_n),
       .ready_strobe(ready_strobe), .app_reset_select(app_reset_select),
       .outputWord(outputWord), .sampleStart(sampleStart),
       .appResetPulse(appResetPulse), .porResetPulse(porResetPulse),
       .cmdWord(cmdWord), .cmdFull(cmdFull), .cmdValid(cmdValid),
       .cmdReady(cmdReady));

  spi_host_model host (.conv_start_select_n(conv_start_select_n),
                       .sclk(sclk), .serialIn(serialIn),
                       .primary_serial_out(sdoLine));

  // core clock, 8 ns period
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  // a released data line floats to the inverse of its last driven bit
  always @(posedge core_clk)
    if (primarySerialOutEn_n === 1'b0)
      lastSdo <= primary_serial_out;
  assign sdoLine = (primarySerialOutEn_n === 1'b0) ? primary_serial_out
                                                   : ~lastSdo;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp,
                       input string what);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask : check

  task automatic final_report;
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cyc

  // bounded wait for the strobe; n returns the cycles spent
  task automatic wait_strobe;
    n = 0;
    while (ready_strobe !== 1'b1 && n < 3000)
    begin
      cyc(1);
      n++;
    end
    if (n >= 3000)
    begin
      check(0, 1, "strobe timeout");
      final_report();
    end
  endtask : wait_strobe

  // one frame, then end-of-frame pin checks and conversion timing
  task automatic do_frame(input int len, input bit push);
    frame_word_s e;
    logic [63:0] m;
    tx = {$urandom, $urandom};
    outputWord = $urandom;
    e.word = (len >= 32) ? tx[31:0] : NopWord;
    e.longEnough = (len >= 32);
    if (push)
      expQ.push_back(e);
    s0 = startSeen;
    host.frame(tx, len, rx);
    if (len < 32)
      check(rx, outputWord >> (32 - len), "short read");
    else
      check(rx >> (len - 32), outputWord, "word read");
    m = (64'h1 << (len - 32)) - 64'h1;
    if (len > 32)
      check(rx & m, (tx >> 32) & m, "pass through");
    cyc(8);
    check(primarySerialOutEn_n, 1, "out released");
    check(ready_strobe, 0, "strobe low");
    check(startSeen - s0, 1, "one start");
    wait_strobe();
    check(n >= ConvN - 8 && n <= ConvN, 1, "conv time");
  endtask : do_frame

  // reset pin, either kind, then recovery
  task automatic do_reset(input bit sel);
    int a0, p0;
    a0 = appSeen;
    p0 = porSeen;
    app_reset_select = sel;
    async_reset_n = 1'b0;
    cyc(8);
    check(appSeen - a0, sel, "app reset");
    check(porSeen - p0, !sel, "por reset");
    check(ready_strobe, 0, "strobe in reset");
    check(primarySerialOutEn_n, 1, "tristate");
    // leave reset with select low; its later rise falls in reset
    host.hold_select(1'b0);
    cyc(2);
    async_reset_n = 1'b1;
    cyc(2);
    host.hold_select(1'b1);
    wait_strobe();
    check(n >= (sel ? AppN : PorN) - 4 && n <= (sel ? AppN : PorN) + 8,
          1, "recovery");
  endtask : do_reset

  // pulse counters
  always @(posedge core_clk)
  begin
    if (appResetPulse === 1'b1) appSeen++;
    if (porResetPulse === 1'b1) porSeen++;
    if (sampleStart === 1'b1) startSeen++;
  end

  // result watcher: each accepted word against the oldest note
  always @(posedge core_clk)
    if (nrst === 1'b1 && cmdValid === 1'b1 && cmdReady === 1'b1)
    begin
      if (expQ.size() == 0)
        check(1, 0, "unexpected word");
      else
      begin
        got = expQ.pop_front();
        check(cmdWord, got.word, "cmd word");
        check(cmdFull, got.longEnough, "cmd full");
      end
    end

  // main sequence
  initial
  begin
    void'($urandom(32'h54e7));
    failures = 0; comparisons = 0; appSeen = 0; porSeen = 0; startSeen = 0;
    nrst = 1'b0; async_reset_n = 1'b1; app_reset_select = 1'b0;
    cmdReady = 1'b1; outputWord = 32'h0000_0000;
    cyc(5);
    nrst = 1'b1;
    wait_strobe();
    check(n >= PorN - 4, 1, "power-up wait");
    do_frame(32, 1);
    do_frame(16, 1);
    do_frame(31, 1);
    do_frame(40, 1);
    do_frame(64, 1);
    // select edges inside a conversion must not count
    do_frame(32, 1);
    tx = {$urandom, $urandom};
    expQ.push_back('{tx[31:0], 1'b1});
    host.frame(tx, 32, rx);
    cyc(8);
    s0 = startSeen;
    host.pulse_select(48);
    cyc(ConvN - 20);
    check(startSeen - s0, 0, "edges ignored");
    check(ready_strobe, 0, "strobe held low");
    wait_strobe();
    // fill the fifo while the far side stalls, fifth word dropped
    cmdReady = 1'b0;
    repeat (4) do_frame(32, 1);
    do_frame(32, 0);
    repeat (60)
    begin
      cmdReady = $urandom % 2;
      cyc(1);
    end
    cmdReady = 1'b1;
    cyc(4);
    check(expQ.size(), 0, "fifo drained");
    // random lengths with the far side always ready
    repeat (6) do_frame(8 + $urandom % 57, 1);
    do_reset(1'b1);
    do_reset(1'b0);
    do_frame(32, 1);
    cyc(10);
    check(expQ.size(), 0, "all words seen");
    final_report();
  end
endmodule : adc_serial_state_tb
`default_nettype wire
